// ==== core/rrl_pkg.sv ====
package rrl_pkg;

	localparam int unsigned CLK_HZ      = 50_000_000;
	localparam int unsigned NUM_RELAYS  = 4;
	localparam int unsigned ENTRIES     = 40;
	localparam int unsigned ADDR_W      = 6;
	localparam int unsigned ID_W        = 28;
	localparam int unsigned BTN_W       = 4;
	localparam int unsigned REL_W       = 2;
	localparam int unsigned ENT_W       = ID_W + BTN_W + REL_W;

	// entry layout: identity, button, relay index
	localparam int unsigned ENT_REL_LSB = 0;
	localparam int unsigned ENT_BTN_LSB = REL_W;
	localparam int unsigned ENT_ID_LSB  = REL_W + BTN_W;

	// times as given, in their own unit
	localparam int unsigned ERASE_TIME_S    = 10;
	localparam int unsigned OPERATE_MAX_MS  = 100;
	localparam int unsigned RELEASE_MAX_MS  = 300;
	// repeat gap kept below the release limit so release always meets it
	localparam int unsigned HOLD_TIME_MS    = 250;
	localparam int unsigned FLASH_TIME_MS   = 200;
	localparam int unsigned DONE_FLASHES    = 3;

	function automatic int unsigned ms_to_cycles(input int unsigned ms);
		return ms * (CLK_HZ / 1000);
	endfunction

	localparam int unsigned ERASE_CYCLES_DEF = ms_to_cycles(ERASE_TIME_S * 1000);
	localparam int unsigned HOLD_CYCLES_DEF  = ms_to_cycles(HOLD_TIME_MS);
	localparam int unsigned FLASH_CYCLES_DEF = ms_to_cycles(FLASH_TIME_MS);
	// a lookup walks every entry once plus a few cycles of setup
	localparam int unsigned SCAN_CYCLES      = ENTRIES + 3;

	localparam logic [31:0] CNT_RST = 32'h0000_0000;

	typedef enum logic [2:0] {
		SC_IDLE = 3'h1,
		SC_RUN  = 3'h2,
		SC_DONE = 3'h4
	} rrl_scan_t;

	typedef enum logic [4:0] {
		LN_OFF    = 5'h01,
		LN_SELFL  = 5'h02,
		LN_ARMED  = 5'h04,
		LN_WAIT2  = 5'h08,
		LN_DONEFL = 5'h10
	} rrl_learn_t;

endpackage

// ==== core/rrl_pair_mem.sv ====
module rrl_pair_mem (
	input  wire logic                        clk_in,
	input  wire logic                        rst_in,
	input  wire logic                        clr_in,
	input  wire logic                        we_in,
	input  wire logic [rrl_pkg::ADDR_W-1:0]  waddr_in,
	input  wire logic [rrl_pkg::ENT_W-1:0]   wdata_in,
	input  wire logic [rrl_pkg::ADDR_W-1:0]  raddr_in,
	output logic      [rrl_pkg::ENT_W-1:0]   rdata_out,
	output logic                             rvalid_out
);
	import rrl_pkg::*;

	logic [ENT_W-1:0]   mem_q [0:ENTRIES-1];
	logic [ENTRIES-1:0] valid_q;

	wire r_in_range = 32'(raddr_in) < ENTRIES;
	wire w_in_range = 32'(waddr_in) < ENTRIES;

	always_ff @(posedge clk_in) begin
		if (we_in && w_in_range)
			mem_q[waddr_in] <= wdata_in;
	end

	// whole-table clear only; no per-entry erase exists
	always_ff @(posedge clk_in) begin
		if (rst_in || clr_in)
			valid_q <= '0;
		else if (we_in && w_in_range)
			valid_q[waddr_in] <= 1'b1;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rdata_out  <= '0;
			rvalid_out <= 1'b0;
		end else begin
			rdata_out  <= r_in_range ? mem_q[raddr_in] : '0;
			rvalid_out <= r_in_range && valid_q[raddr_in];
		end
	end

endmodule

// ==== core/rrl_controller.sv ====
// Functional notes
// - pair by sender identity plus button code
// - table holds at most forty pairings
// - four relays, any button, many relays
// - one learn sequence stores one pairing
// - first brief press selects relay one, flash
// - wait for flash end; presses advance
// - message while selected lights LED steadily
// - same button again stores, then flashes
// - stored pairing operates its relay afterwards
// - ten second hold erases, LED off
// - erase always clears the whole table
// - jumpers pick momentary or latching per relay
// - relay output high means contact common to open
// - relay operates within 100 ms
// - momentary relay releases within 300 ms
module rrl_controller #(
	parameter int unsigned ERASE_CYCLES = rrl_pkg::ERASE_CYCLES_DEF,
	parameter int unsigned HOLD_CYCLES  = rrl_pkg::HOLD_CYCLES_DEF,
	parameter int unsigned FLASH_CYCLES = rrl_pkg::FLASH_CYCLES_DEF
) (
	input  wire logic                      MCLK_IN,
	input  wire logic                      RST_IN,
	input  wire logic                      MSG_VALID_IN,
	input  wire logic [rrl_pkg::ID_W-1:0]  MSG_ID_IN,
	input  wire logic [rrl_pkg::BTN_W-1:0] MSG_BUTTON_IN,
	input  wire logic                      LEARN_PUSHBUTTON_IN,
	input  wire logic                      MODE_JUMPER_A_IN,
	input  wire logic                      MODE_JUMPER_B_IN,
	output logic                           RELAY_OUT_FIRST_OUT,
	output logic                           RELAY_OUT_SECOND_OUT,
	output logic                           RELAY_OUT_THIRD_OUT,
	output logic                           RELAY_OUT_FOURTH_OUT,
	output logic                           LEARN_LED_OUT
);
	import rrl_pkg::*;

	function automatic logic [NUM_RELAYS-1:0] rel_onehot(input logic [REL_W-1:0] r);
		return NUM_RELAYS'(1) << r;
	endfunction

	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (RST_IN);

	////////////////////////////////////////////////////////////////////////
	// learn push-button: edges, hold timer, erase

	logic        btn_q;
	logic [31:0] press_cnt_q;
	logic        erased_q;

	wire btn_fall    = !LEARN_PUSHBUTTON_IN && btn_q;
	wire erase_go    = LEARN_PUSHBUTTON_IN && !erased_q
	                   && press_cnt_q == 32'(ERASE_CYCLES - 1);
	// a release after an erase is not a brief press
	wire brief_press = btn_fall && !erased_q;
	wire hold_lit    = LEARN_PUSHBUTTON_IN && !erased_q && press_cnt_q >= FLASH_CYCLES;

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			btn_q       <= 1'b0;
			press_cnt_q <= CNT_RST;
			erased_q    <= 1'b0;
		end else begin
			btn_q       <= LEARN_PUSHBUTTON_IN;
			press_cnt_q <= !LEARN_PUSHBUTTON_IN ? CNT_RST :
			               (press_cnt_q < ERASE_CYCLES) ? press_cnt_q + 32'h0000_0001 :
			               press_cnt_q;
			erased_q    <= LEARN_PUSHBUTTON_IN && (erased_q || erase_go);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// message gap: a message after a full quiet gap counts as a new press

	logic [31:0] quiet_q;
	wire quiet_full = quiet_q >= HOLD_CYCLES;

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN)
			quiet_q <= 32'(HOLD_CYCLES);
		else if (MSG_VALID_IN)
			quiet_q <= CNT_RST;
		else if (!quiet_full)
			quiet_q <= quiet_q + 32'h0000_0001;
	end

	////////////////////////////////////////////////////////////////////////
	// table lookup, one entry per cycle

	rrl_scan_t              scan_q;
	logic [ADDR_W-1:0]      addr_q;
	logic                   chk_q;
	logic [ID_W-1:0]        id_q;
	logic [BTN_W-1:0]       code_q;
	logic                   np_q;
	logic [NUM_RELAYS-1:0]  hit_q;
	logic                   dup_q;
	logic                   free_ok_q;
	logic [ADDR_W-1:0]      free_idx_q;
	logic [ENT_W-1:0]       rd_data;
	logic                   rd_valid;
	logic [REL_W-1:0]       sel_q;

	wire [ID_W-1:0]  rd_id   = rd_data[ENT_ID_LSB +: ID_W];
	wire [BTN_W-1:0] rd_btn  = rd_data[ENT_BTN_LSB +: BTN_W];
	wire [REL_W-1:0] rd_rel  = rd_data[ENT_REL_LSB +: REL_W];
	// messages during a lookup are dropped; repeats arrive well inside the limits
	wire scan_start = scan_q == SC_IDLE && MSG_VALID_IN;
	wire scan_last  = scan_q == SC_RUN && 32'(addr_q) == ENTRIES;
	wire scan_done  = scan_q == SC_DONE;
	wire ent_hit    = chk_q && rd_valid && rd_id == id_q && rd_btn == code_q;
	wire ent_free   = chk_q && !rd_valid && !free_ok_q;
	// the current check cycle belongs to the entry one below addr_q
	wire [ADDR_W-1:0] chk_idx = addr_q - ADDR_W'(1);

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			scan_q <= SC_IDLE;
			addr_q <= '0;
			chk_q  <= 1'b0;
		end else begin
			case (scan_q)
				SC_IDLE: scan_q <= scan_start ? SC_RUN : SC_IDLE;
				SC_RUN:  scan_q <= scan_last ? SC_DONE : SC_RUN;
				SC_DONE: scan_q <= SC_IDLE;
				default: scan_q <= SC_IDLE;
			endcase
			addr_q <= scan_start ? '0 : (scan_q == SC_RUN && !scan_last) ? addr_q + ADDR_W'(1) : addr_q;
			chk_q  <= scan_q == SC_RUN && 32'(addr_q) < ENTRIES;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			id_q       <= '0;
			code_q     <= '0;
			np_q       <= 1'b0;
			hit_q      <= '0;
			dup_q      <= 1'b0;
			free_ok_q  <= 1'b0;
			free_idx_q <= '0;
		end else if (scan_start) begin
			id_q      <= MSG_ID_IN;
			code_q    <= MSG_BUTTON_IN;
			np_q      <= quiet_full;
			hit_q     <= '0;
			dup_q     <= 1'b0;
			free_ok_q <= 1'b0;
		end else begin
			if (ent_hit)
				hit_q <= hit_q | rel_onehot(rd_rel);
			if (ent_hit && rd_rel == sel_q)
				dup_q <= 1'b1;
			if (ent_free) begin
				free_ok_q  <= 1'b1;
				free_idx_q <= chk_idx;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// learn sequence and LED

	rrl_learn_t  ln_q;
	rrl_learn_t  ln_d;
	logic [REL_W-1:0] sel_d;
	logic [ID_W-1:0]  lid_q;
	logic [BTN_W-1:0] lbtn_q;
	logic [3:0]       flash_left_q;
	logic [31:0]      flash_tmr_q;
	logic             flash_start;
	logic [3:0]       flash_len;
	logic             led_q;

	wire flash_busy = flash_left_q != 4'h0;
	wire second_ok  = np_q && id_q == lid_q && code_q == lbtn_q;
	wire learn_we   = scan_done && ln_q == LN_WAIT2 && second_ok && free_ok_q && !dup_q;
	wire [ENT_W-1:0] learn_wdata = {lid_q, lbtn_q, sel_q};

	always_comb begin
		ln_d        = ln_q;
		sel_d       = sel_q;
		flash_start = 1'b0;
		flash_len   = 4'h0;
		case (ln_q)
			LN_OFF: if (brief_press) begin
				ln_d        = LN_SELFL;
				sel_d       = '0;
				flash_start = 1'b1;
				flash_len   = 4'h2;
			end
			LN_SELFL: if (!flash_busy)
				ln_d = LN_ARMED;  // presses while flashing are ignored
			LN_ARMED: if (brief_press) begin
				if (sel_q == REL_W'(NUM_RELAYS - 1)) begin
					ln_d = LN_OFF;
				end else begin
					ln_d        = LN_SELFL;
					sel_d       = sel_q + REL_W'(1);
					flash_start = 1'b1;
					flash_len   = 4'({sel_q, 1'b0}) + 4'h4;
				end
			end else if (scan_done) begin
				ln_d = LN_WAIT2;
			end
			LN_WAIT2: if (scan_done && second_ok) begin
				// full table and not already paired: nothing stored and no completion flash
				if (free_ok_q || dup_q) begin
					ln_d        = LN_DONEFL;
					flash_start = 1'b1;
					flash_len   = 4'(2 * DONE_FLASHES);
				end else begin
					ln_d = LN_OFF;
				end
			end
			LN_DONEFL: if (!flash_busy)
				ln_d = LN_OFF;
			default: ln_d = LN_OFF;
		endcase
		if (erase_go) begin
			ln_d        = LN_OFF;
			flash_start = 1'b0;
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN) begin
			ln_q   <= LN_OFF;
			sel_q  <= '0;
			lid_q  <= '0;
			lbtn_q <= '0;
		end else begin
			ln_q  <= ln_d;
			sel_q <= sel_d;
			if (ln_q == LN_ARMED && scan_done) begin
				lid_q  <= id_q;
				lbtn_q <= code_q;
			end
		end
	end

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN || erase_go) begin
			flash_left_q <= 4'h0;
			flash_tmr_q  <= CNT_RST;
		end else if (flash_start) begin
			flash_left_q <= flash_len;
			flash_tmr_q  <= CNT_RST;
		end else if (flash_busy) begin
			if (flash_tmr_q == 32'(FLASH_CYCLES - 1)) begin
				flash_tmr_q  <= CNT_RST;
				flash_left_q <= flash_left_q - 4'h1;
			end else begin
				flash_tmr_q <= flash_tmr_q + 32'h0000_0001;
			end
		end
	end

	// steady in second wait, blinks while flashing, lit in a long hold, dark at erase
	wire led_d = !erase_go
	             && ((ln_q == LN_WAIT2) || (flash_busy && !flash_left_q[0]) || hold_lit);

	always_ff @(posedge MCLK_IN) begin
		if (RST_IN)
			led_q <= 1'b0;
		else
			led_q <= led_d;
	end

	rrl_pair_mem u_mem (
		.clk_in     (MCLK_IN),
		.rst_in     (RST_IN),
		.clr_in     (erase_go),
		.we_in      (learn_we),
		.waddr_in   (free_idx_q),
		.wdata_in   (learn_wdata),
		.raddr_in   (addr_q),
		.rdata_out  (rd_data),
		.rvalid_out (rd_valid)
	);

	////////////////////////////////////////////////////////////////////////
	// relays: per-relay hold timer and toggle state

	logic [31:0]           tmr_q [NUM_RELAYS];
	logic [NUM_RELAYS-1:0] latch_q;
	logic [NUM_RELAYS-1:0] relay_q;

	wire [NUM_RELAYS-1:0] hit_now = scan_done ? hit_q : '0;
	// closed jumper reads high; bit set means latching
	wire [NUM_RELAYS-1:0] latch_mask =
		( MODE_JUMPER_A_IN &&  MODE_JUMPER_B_IN) ? 4'h0 :
		( MODE_JUMPER_A_IN && !MODE_JUMPER_B_IN) ? 4'hC :
		(!MODE_JUMPER_A_IN &&  MODE_JUMPER_B_IN) ? 4'hE : 4'hF;

	for (genvar i = 0; i < NUM_RELAYS; i++) begin : g_rel
		always_ff @(posedge MCLK_IN) begin
			if (RST_IN) begin
				tmr_q[i]   <= CNT_RST;
				latch_q[i] <= 1'b0;
				relay_q[i] <= 1'b0;
			end else begin
				tmr_q[i]   <= hit_now[i] ? 32'(HOLD_CYCLES) :
				              (tmr_q[i] != CNT_RST) ? tmr_q[i] - 32'h0000_0001 : tmr_q[i];
				latch_q[i] <= latch_q[i] ^ (hit_now[i] && np_q);
				relay_q[i] <= latch_mask[i] ? latch_q[i] : (tmr_q[i] != CNT_RST);
			end
		end
	end

	assign RELAY_OUT_FIRST_OUT  = relay_q[0];
	assign RELAY_OUT_SECOND_OUT = relay_q[1];
	assign RELAY_OUT_THIRD_OUT  = relay_q[2];
	assign RELAY_OUT_FOURTH_OUT = relay_q[3];
	assign LEARN_LED_OUT        = led_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	a_scan_bounded: assert property (scan_start |-> ##[1:45] scan_done)
		else $error("lookup did not finish in time");

	a_mom_follows: assert property (hit_now[0] && !latch_mask[0]
		&& !$changed(latch_mask) |-> ##2 RELAY_OUT_FIRST_OUT)
		else $error("momentary relay not energised after match");

	a_latch_toggle: assert property (hit_now[3] && np_q && latch_mask[3]
		&& $stable(latch_mask) |-> ##2 (RELAY_OUT_FOURTH_OUT != $past(latch_q[3], 2)))
		else $error("latching relay did not toggle");

	// led register follows the flash counter one edge later
	a_first_select: assert property (ln_q == LN_OFF && brief_press && !erase_go
		|=> sel_q == '0 && ln_q == LN_SELFL ##1 LEARN_LED_OUT)
		else $error("first press did not select relay one");

	a_flash_holds: assert property (ln_q == LN_SELFL && flash_busy |=> $stable(sel_q))
		else $error("selection moved while flashing");

	a_wait_steady: assert property (ln_q == LN_WAIT2 && !erase_go |=> LEARN_LED_OUT)
		else $error("led not steady while waiting");

	a_store_match: assert property (learn_we |-> id_q == lid_q && code_q == lbtn_q
		&& free_ok_q ##1 ln_q == LN_DONEFL)
		else $error("store without matching second press");

	a_erase_off: assert property (erase_go |=> ln_q == LN_OFF && !LEARN_LED_OUT
		##1 !rd_valid [*3])
		else $error("erase left state or led behind");

	a_full_nostore: assert property (scan_done && !free_ok_q |-> !learn_we)
		else $error("store into full table");

	c_store: cover property (learn_we ##[1:20] ln_q == LN_DONEFL);
	c_erase: cover property (erase_go);
	c_latch: cover property (hit_now[3] && np_q && latch_mask[3]);
	c_second_relay: cover property (ln_q == LN_SELFL && sel_q == REL_W'(1));

endmodule

// ==== verification/rrl_tx_model.sv ====
module rrl_tx_model (
	input  wire logic                      clk_in,
	output logic                           msg_valid_out,
	output logic [rrl_pkg::ID_W-1:0]       msg_id_out,
	output logic [rrl_pkg::BTN_W-1:0]      msg_button_out
);
	timeunit 1ns;
	timeprecision 1ps;
	import rrl_pkg::*;

	initial begin
		msg_valid_out = 1'b0;
		msg_id_out = '0;
		msg_button_out = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// each message names sender and button together
	// repeats every 50 cycles: above the lookup time, below the hold time
	task automatic press(input logic [ID_W-1:0] id, input logic [BTN_W-1:0] btn, input int reps);
		for (int i = 0; i < reps; i++) begin
			@(posedge clk_in);
			#1;
			msg_valid_out = 1'b1;
			msg_id_out = id;
			msg_button_out = btn;
			@(posedge clk_in);
			#1;
			msg_valid_out = 1'b0;
			// no stale copy left on the lines between messages
			msg_id_out = ~id;
			msg_button_out = ~btn;
			repeat (48) @(posedge clk_in);
		end
	endtask
endmodule

// ==== verification/remote_relay_learn_controller_test.sv ====
module remote_relay_learn_controller_test;
	timeunit 1ns;
	timeprecision 1ps;
	import rrl_pkg::*;

	localparam int unsigned FLASH = 20;
	localparam int unsigned HOLD  = 60;
	localparam int unsigned ERASE = 200;
	localparam logic [ID_W-1:0]  ID_A  = 28'h123_4567;
	localparam logic [ID_W-1:0]  ID_B  = 28'h0ab_0000;
	localparam logic [ID_W-1:0]  ID_C  = 28'h0fe_dcba;
	localparam logic [BTN_W-1:0] BTN_A = 4'h3;
	localparam logic [BTN_W-1:0] BTN_B = 4'h5;

	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              learn_btn = 1'b0;
	logic              jmp_a = 1'b1;
	logic              jmp_b = 1'b1;
	logic              msg_valid;
	logic [ID_W-1:0]   msg_id;
	logic [BTN_W-1:0]  msg_button;
	logic              rly_first;
	logic              rly_second;
	logic              rly_third;
	logic              rly_fourth;
	logic              led;
	logic [3:0]        rly;
	int                num_errors = 0;
	int                cmp_count = 0;

	assign rly = {rly_fourth, rly_third, rly_second, rly_first};

	always #10 clk = ~clk;

	rrl_controller #(
		.ERASE_CYCLES (ERASE),
		.HOLD_CYCLES  (HOLD),
		.FLASH_CYCLES (FLASH)
	) i_rrl_controller (
		.MCLK_IN              (clk),
		.RST_IN               (rst),
		.MSG_VALID_IN         (msg_valid),
		.MSG_ID_IN            (msg_id),
		.MSG_BUTTON_IN        (msg_button),
		.LEARN_PUSHBUTTON_IN  (learn_btn),
		.MODE_JUMPER_A_IN     (jmp_a),
		.MODE_JUMPER_B_IN     (jmp_b),
		.RELAY_OUT_FIRST_OUT  (rly_first),
		.RELAY_OUT_SECOND_OUT (rly_second),
		.RELAY_OUT_THIRD_OUT  (rly_third),
		.RELAY_OUT_FOURTH_OUT (rly_fourth),
		.LEARN_LED_OUT        (led)
	);

	rrl_tx_model i_rrl_tx_model (
		.clk_in         (clk),
		.msg_valid_out  (msg_valid),
		.msg_id_out     (msg_id),
		.msg_button_out (msg_button)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic results;
		$display("counts: comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic press(input logic [ID_W-1:0] id, input logic [BTN_W-1:0] btn, input int reps);
		i_rrl_tx_model.press(id, btn, reps);
		#1;
	endtask

	// brief learn presses up to relay n, then two presses of the button
	task automatic learn(input logic [ID_W-1:0] id, input logic [BTN_W-1:0] btn, input int n,
	                     input logic fl);
		for (int k = 1; k <= n; k++) begin
			learn_btn = 1'b1;
			cyc(2);
			learn_btn = 1'b0;
			cyc(3);
			check(32'(led), 32'h0000_0001);
			cyc(2 * k * FLASH + 10);
		end
		press(id, btn, 1);
		check(32'(led), 32'h0000_0001);
		cyc(70);
		// completion flash still on here; a full table stays dark
		press(id, btn, 1);
		check(32'(led), 32'(fl));
		cyc(150);
		check(32'(led), 32'h0000_0000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		check(32'({led, rly}), 32'h0000_0000);
		$display("test reset done");
	endtask

	task automatic t_modes;
		logic [3:0] mom;
		for (int r = 1; r <= 4; r++) begin
			learn(ID_A, BTN_A, r, 1'b1);
		end
		for (int c = 0; c < 4; c++) begin
			{jmp_a, jmp_b} = 2'(c);
			case (c)
				3: mom = 4'hf;
				2: mom = 4'h3;
				1: mom = 4'h1;
				default: mom = 4'h0;
			endcase
			// held button: three messages must still toggle latching relays once
			press(ID_A, BTN_A, 3);
			check(32'(rly), 32'h0000_000f);
			cyc(HOLD + 60);
			check(32'(rly), 32'(mom ^ 4'hf));
			press(ID_A, BTN_A, 1);
			cyc(HOLD + 60);
			check(32'(rly), 32'h0000_0000);
		end
		{jmp_a, jmp_b} = 2'b11;
		$display("test modes done");
	endtask

	task automatic t_unmatched;
		press(ID_A, BTN_B, 1);
		check(32'(rly), 32'h0000_0000);
		cyc(HOLD + 20);
		press(ID_B, BTN_A, 1);
		check(32'(rly), 32'h0000_0000);
		cyc(HOLD + 20);
		$display("test unmatched done");
	endtask

	task automatic t_learn_edges;
		// already paired: completion flash, but no entry used; capacity relies on it
		learn(ID_A, BTN_A, 1, 1'b1);
		// a press with relay four selected leaves learn at once
		for (int k = 1; k <= 5; k++) begin
			learn_btn = 1'b1;
			cyc(2);
			learn_btn = 1'b0;
			cyc(3);
			check(32'(led), 32'(k < 5));
			cyc(2 * k * FLASH + 10);
		end
		press(ID_C, BTN_B, 1);
		check(32'({led, rly}), 32'h0000_0000);
		cyc(HOLD + 20);
		$display("test learn edges done");
	endtask

	task automatic t_capacity;
		// four entries already held for the button on all relays
		for (int i = 0; i < 36; i++) begin
			learn(ID_B + ID_W'(i), BTN_A, 1, 1'b1);
		end
		learn(ID_C, BTN_A, 1, 1'b0);
		press(ID_C, BTN_A, 1);
		check(32'(rly), 32'h0000_0000);
		cyc(HOLD + 60);
		press(ID_B + ID_W'(35), BTN_A, 1);
		check(32'(rly), 32'h0000_0001);
		cyc(HOLD + 60);
		$display("test capacity done");
	endtask

	task automatic t_erase;
		learn_btn = 1'b1;
		cyc(FLASH + 10);
		check(32'(led), 32'h0000_0001);
		cyc(ERASE);
		check(32'(led), 32'h0000_0000);
		learn_btn = 1'b0;
		cyc(5);
		check(32'(led), 32'h0000_0000);
		press(ID_A, BTN_A, 1);
		check(32'(rly), 32'h0000_0000);
		cyc(HOLD + 20);
		press(ID_B, BTN_A, 1);
		check(32'(rly), 32'h0000_0000);
		$display("test erase done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		cyc(1);
		t_reset();
		t_modes();
		t_unmatched();
		t_learn_edges();
		t_capacity();
		t_erase();
		results();
	end

	// whole run needs about 20k cycles
	initial begin
		repeat (80000) @(posedge clk);
		num_errors++;
		$display("watchdog expired at t=%0t", $time);
		results();
	end
endmodule
